// ===== tmrsc_pkg.sv
// Package with the register map, field layout, reset values and types of the timer status block.
package tmrsc_pkg;
    // Clock figures: the core clock period in nanoseconds.
    localparam int CORE_CLK_PERIOD_NS = 100;

    // Register byte offsets.
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNTER_HIGH = 8'h01;
    localparam logic [7:0] OFS_COUNTER_LOW = 8'h02;
    localparam logic [7:0] OFS_MODULO_HIGH = 8'h03;
    localparam logic [7:0] OFS_MODULO_LOW = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h09;

    // Field positions inside the status/control register.
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_OVERFLOW_IRQ_ENABLE = 6;
    localparam int BIT_CENTER_ALIGNED = 5;
    localparam int BIT_CLOCK_SOURCE_LSB = 3;
    localparam int BIT_PRESCALE_LSB = 0;
    // Position of the overflow event in the interrupt status and mask registers.
    localparam int BIT_IRQ_OVERFLOW = 0;

    // Reset values.
    localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [15:0] RST_MODULO = 16'h0000;
    localparam logic [7:0] RST_IRQ = 8'h00;

    // Clock source codes.
    typedef enum logic [1:0] {
        TMRSC_CLK_NONE = 2'h0,
        TMRSC_CLK_SYSTEM = 2'h1,
        TMRSC_CLK_FIXED = 2'h2,
        TMRSC_CLK_EXTERNAL = 2'h3
    } tmrsc_clk_src_e;

    // Register bus request travelling from the master.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmrsc_bus_req_s;
endpackage

// ===== tmrsc_prescaler.sv
// Counter clock source selection and power-of-two prescaler producing one-cycle count ticks.
`timescale 1ns/1ps
module tmrsc_prescaler (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Configuration from the status/control register, and the debug freeze.
    input wire tmrsc_pkg::tmrsc_clk_src_e clock_source_select,
    input wire logic [2:0] prescale_select,
    input wire logic freeze,
    // Clock inputs, synchronous to core_clk.
    input wire logic fixed_clk_in,
    input wire logic ext_clk_in,
    // Count tick, one cycle wide.
    output logic count_tick
);
    // Previous levels of the slow clocks, for rising edge detection.
    logic fixed_prev_reg;
    logic ext_prev_reg;
    // Free running divider advanced on each selected source edge.
    logic [6:0] div_reg;
    // One-cycle pulse of the selected source.
    logic src_pulse;
    // Divider bits that must all be one for a tick.
    logic [6:0] div_mask;

    // Sample the slow clocks to find their rising edges.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fixed_prev_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            fixed_prev_reg <= fixed_clk_in;
            ext_prev_reg <= ext_clk_in;
        end
    end

    // Pick the source; code none yields no pulse so the counter stops.
    always_comb begin
        unique case (clock_source_select)
            tmrsc_pkg::TMRSC_CLK_NONE: src_pulse = 1'b0;
            tmrsc_pkg::TMRSC_CLK_SYSTEM: src_pulse = 1'b1;
            tmrsc_pkg::TMRSC_CLK_FIXED: src_pulse = fixed_clk_in & ~fixed_prev_reg;
            tmrsc_pkg::TMRSC_CLK_EXTERNAL: src_pulse = ext_clk_in & ~ext_prev_reg;
        endcase
        // The mask is read straight from the register bits, so a new factor acts on the next cycle.
        div_mask = 7'((8'h01 << prescale_select) - 8'h01);
    end

    // The divider holds during debug so the prescale phase is kept as well.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= 7'h00;
            count_tick <= 1'b0;
        end else begin
            count_tick <= src_pulse & ~freeze & ((div_reg & div_mask) == div_mask);
            if (src_pulse && !freeze) begin
                div_reg <= div_reg + 7'h01;
            end
        end
    end
endmodule

// ===== tmrsc_core.sv
// Timer status/control register, 16-bit counter, coherent counter readout and overflow interrupt.
//
// Contract
// - Overflow flag, bit 7, set when counter passes modulo.
// - Flag clears by read-while-set then write zero.
// - Overflow between read and write cancels the clear.
// - Enable bit 6 gates overflow request.
// - Bit 5 selects up or up-down counting.
// - Bits 4..3 pick none, system, fixed, external.
// - Prescale field divides by 1 through 128.
// - New prescale acts on the next cycle.
// - Reading either byte latches both until other read.
// - Reset or status write unlatches the readout.
// - Counter byte write zeroes counter, unlatches readout.
// - Debug freezes the counter; reads show it.
// - Debug freezes readout latch state despite reads.
// - Status/control at offset 0, fields, reset zero.
// - Flag sets on the tick after reaching modulo.
`timescale 1ns/1ps
module tmrsc_core (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register bus.
    input wire tmrsc_pkg::tmrsc_bus_req_s bus_req,
    output logic [7:0] reg_rdata,
    // Clock inputs and debug state.
    input wire logic fixed_clk_in,
    input wire logic ext_clk_in,
    input wire logic background_debug_active,
    // Interrupt outputs.
    output logic overflow_irq_req,
    output logic irq
);
    // Readout latch states.
    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_HELD_HIGH_READ = 3'h2,
        RD_HELD_LOW_READ = 3'h4
    } tmrsc_rd_state_e;

    // Status/control fields.
    logic overflow_flag_reg;
    logic overflow_irq_enable_reg;
    logic center_aligned_select_reg;
    tmrsc_pkg::tmrsc_clk_src_e clock_source_select_reg;
    logic [2:0] prescale_select_reg;
    // Set by a status read while the flag is one; a later zero write may then clear.
    logic clear_armed_reg;
    // Counter, modulo and count direction (1 means counting down).
    logic [15:0] counter_reg;
    logic [15:0] modulo_reg;
    logic count_down_reg;
    // Readout latch.
    tmrsc_rd_state_e rd_state_reg;
    logic [15:0] held_value_reg;
    // Interrupt status and mask.
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    // Tick from the prescaler and the overflow event of this cycle.
    logic count_tick;
    logic overflow_event;
    // Decoded accesses.
    logic wr_sc;
    logic rd_sc;
    logic wr_cnt;
    logic rd_cnt_hi;
    logic rd_cnt_lo;
    logic [7:0] rdata_next;

    // Top of the count; a zero modulo means free running over the full range.
    function automatic logic [15:0] count_top(input logic [15:0] modulo);
        count_top = (modulo == 16'h0000) ? 16'hFFFF : modulo;
    endfunction

    // Address match for a single byte register.
    function automatic logic hit(input tmrsc_pkg::tmrsc_bus_req_s req, input logic [7:0] ofs);
        hit = (req.addr == ofs);
    endfunction

    // Access decode.
    assign wr_sc = bus_req.wr & hit(bus_req, tmrsc_pkg::OFS_STATUS_CONTROL);
    assign rd_sc = bus_req.rd & hit(bus_req, tmrsc_pkg::OFS_STATUS_CONTROL);
    assign wr_cnt = bus_req.wr
        & (hit(bus_req, tmrsc_pkg::OFS_COUNTER_HIGH) | hit(bus_req, tmrsc_pkg::OFS_COUNTER_LOW));
    assign rd_cnt_hi = bus_req.rd & hit(bus_req, tmrsc_pkg::OFS_COUNTER_HIGH);
    assign rd_cnt_lo = bus_req.rd & hit(bus_req, tmrsc_pkg::OFS_COUNTER_LOW);
    // A tick arriving while the counter sits at its top is the overflow; the flag follows on that same edge.
    // Debug masks the tick here too, because one tick may still sit in the prescaler flop on entry.
    assign overflow_event = count_tick & ~background_debug_active
        & (counter_reg == count_top(modulo_reg)) & ~wr_cnt;

    // Clock source and prescaler.
    tmrsc_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst(rst),
        .clock_source_select(clock_source_select_reg),
        .prescale_select(prescale_select_reg),
        .freeze(background_debug_active),
        .fixed_clk_in(fixed_clk_in),
        .ext_clk_in(ext_clk_in),
        .count_tick(count_tick)
    );

    // Control fields of the status/control register; all reset to zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_irq_enable_reg <= tmrsc_pkg::RST_STATUS_CONTROL[tmrsc_pkg::BIT_OVERFLOW_IRQ_ENABLE];
            center_aligned_select_reg <= tmrsc_pkg::RST_STATUS_CONTROL[tmrsc_pkg::BIT_CENTER_ALIGNED];
            clock_source_select_reg <= tmrsc_pkg::TMRSC_CLK_NONE;
            prescale_select_reg <= tmrsc_pkg::RST_STATUS_CONTROL[tmrsc_pkg::BIT_PRESCALE_LSB +: 3];
        end else if (wr_sc) begin
            overflow_irq_enable_reg <= bus_req.wdata[tmrsc_pkg::BIT_OVERFLOW_IRQ_ENABLE];
            center_aligned_select_reg <= bus_req.wdata[tmrsc_pkg::BIT_CENTER_ALIGNED];
            clock_source_select_reg <= tmrsc_pkg::tmrsc_clk_src_e'(
                bus_req.wdata[tmrsc_pkg::BIT_CLOCK_SOURCE_LSB +: 2]);
            prescale_select_reg <= bus_req.wdata[tmrsc_pkg::BIT_PRESCALE_LSB +: 3];
        end
    end

    // Overflow flag with its two-step clear; a fresh overflow always wins over the clearing write.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_flag_reg <= tmrsc_pkg::RST_STATUS_CONTROL[tmrsc_pkg::BIT_OVERFLOW_FLAG];
            clear_armed_reg <= 1'b0;
        end else if (overflow_event) begin
            // An overflow also disarms a pending clear, so the write that follows is ignored.
            overflow_flag_reg <= 1'b1;
            clear_armed_reg <= 1'b0;
        end else if (wr_sc) begin
            // Writing one has no effect; writing zero clears only after a qualifying read.
            if (clear_armed_reg && !bus_req.wdata[tmrsc_pkg::BIT_OVERFLOW_FLAG]) begin
                overflow_flag_reg <= 1'b0;
            end
            clear_armed_reg <= 1'b0;
        end else if (rd_sc && overflow_flag_reg) begin
            clear_armed_reg <= 1'b1;
        end
    end

    // Modulo holds the count top; kept plain here, with no write buffer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            modulo_reg <= tmrsc_pkg::RST_MODULO;
        end else if (bus_req.wr && hit(bus_req, tmrsc_pkg::OFS_MODULO_HIGH)) begin
            modulo_reg[15:8] <= bus_req.wdata;
        end else if (bus_req.wr && hit(bus_req, tmrsc_pkg::OFS_MODULO_LOW)) begin
            modulo_reg[7:0] <= bus_req.wdata;
        end
    end

    // The counter. Debug masks the tick, so the value stays frozen from the first debug cycle on.
    // A tick already in flight when debug begins is dropped; the prescaler phase is kept instead.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            counter_reg <= tmrsc_pkg::RST_COUNTER;
            count_down_reg <= 1'b0;
        end else if (wr_cnt) begin
            // Data is ignored: any counter byte write restarts the count from zero.
            counter_reg <= tmrsc_pkg::RST_COUNTER;
            count_down_reg <= 1'b0;
        end else if (count_tick && !background_debug_active) begin
            if (!center_aligned_select_reg) begin
                // Up counting wraps from the top to zero.
                counter_reg <= overflow_event ? 16'h0000 : counter_reg + 16'h0001;
                count_down_reg <= 1'b0;
            end else if (overflow_event) begin
                // Up-down counting turns at the top.
                counter_reg <= counter_reg - 16'h0001;
                count_down_reg <= 1'b1;
            end else if (count_down_reg && counter_reg == 16'h0000) begin
                // The bottom turn; a top of zero cannot occur because zero means full range.
                counter_reg <= 16'h0001;
                count_down_reg <= 1'b0;
            end else begin
                counter_reg <= count_down_reg ? counter_reg - 16'h0001 : counter_reg + 16'h0001;
            end
        end
    end

    // Readout latch. Status or counter writes restart it even in debug; reads move it only outside debug.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_state_reg <= RD_IDLE;
            held_value_reg <= tmrsc_pkg::RST_COUNTER;
        end else if (wr_sc || wr_cnt) begin
            rd_state_reg <= RD_IDLE;
        end else if (!background_debug_active) begin
            unique case (rd_state_reg)
                RD_IDLE: begin
                    if (rd_cnt_hi) begin
                        rd_state_reg <= RD_HELD_HIGH_READ;
                        held_value_reg <= counter_reg;
                    end else if (rd_cnt_lo) begin
                        rd_state_reg <= RD_HELD_LOW_READ;
                        held_value_reg <= counter_reg;
                    end
                end
                RD_HELD_HIGH_READ: begin
                    if (rd_cnt_lo) begin
                        rd_state_reg <= RD_IDLE;
                    end
                end
                RD_HELD_LOW_READ: begin
                    if (rd_cnt_hi) begin
                        rd_state_reg <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end

    // Interrupt status is sticky and cleared by writing one; a same-cycle event wins over the clear.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_status_reg <= tmrsc_pkg::RST_IRQ;
            irq_mask_reg <= tmrsc_pkg::RST_IRQ;
        end else begin
            if (bus_req.wr && hit(bus_req, tmrsc_pkg::OFS_IRQ_MASK)) begin
                irq_mask_reg <= bus_req.wdata;
            end
            if (overflow_event) begin
                irq_status_reg <= irq_status_reg | (8'h01 << tmrsc_pkg::BIT_IRQ_OVERFLOW);
            end else if (bus_req.wr && hit(bus_req, tmrsc_pkg::OFS_IRQ_STATUS)) begin
                irq_status_reg <= irq_status_reg & ~bus_req.wdata;
            end
        end
    end

    // Interrupt outputs straight from flops, one cycle behind their causes.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflow_irq_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            overflow_irq_req <= overflow_flag_reg & overflow_irq_enable_reg;
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Read data; a held value is returned while the latch holds, the live count otherwise.
    always_comb begin
        rdata_next = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                tmrsc_pkg::OFS_STATUS_CONTROL: begin
                    rdata_next = {overflow_flag_reg, overflow_irq_enable_reg, center_aligned_select_reg,
                                  clock_source_select_reg, prescale_select_reg};
                end
                tmrsc_pkg::OFS_COUNTER_HIGH: begin
                    rdata_next = (rd_state_reg == RD_IDLE) ? counter_reg[15:8] : held_value_reg[15:8];
                end
                tmrsc_pkg::OFS_COUNTER_LOW: begin
                    rdata_next = (rd_state_reg == RD_IDLE) ? counter_reg[7:0] : held_value_reg[7:0];
                end
                tmrsc_pkg::OFS_MODULO_HIGH: rdata_next = modulo_reg[15:8];
                tmrsc_pkg::OFS_MODULO_LOW: rdata_next = modulo_reg[7:0];
                tmrsc_pkg::OFS_IRQ_STATUS: rdata_next = irq_status_reg;
                tmrsc_pkg::OFS_IRQ_MASK: rdata_next = irq_mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Read data register: valid in the cycle after the strobe, zero elsewhere.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // An overflow tick sets the flag on the next edge.
    chk_overflow_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
        overflow_event |=> overflow_flag_reg)
        else $error("overflow flag not set after overflow");

    // A zero write without a preceding qualifying read leaves the flag set.
    chk_flag_clear_needs_read: assert property (@(posedge core_clk) disable iff (rst)
        overflow_flag_reg && !clear_armed_reg |=> overflow_flag_reg)
        else $error("overflow flag cleared without a qualifying read");

    // An overflow sets the flag and disarms any pending clear, so a later zero write cannot lose it.
    chk_clear_lost_overflow: assert property (@(posedge core_clk) disable iff (rst)
        overflow_event |=> overflow_flag_reg && !clear_armed_reg)
        else $error("clearing write won over a new overflow");

    // Writing one to the flag never clears it, armed or not.
    chk_flag_write_one: assert property (@(posedge core_clk) disable iff (rst)
        overflow_flag_reg && wr_sc && bus_req.wdata[tmrsc_pkg::BIT_OVERFLOW_FLAG] |=> overflow_flag_reg)
        else $error("writing one cleared the overflow flag");

    // A readout latched by a high-byte read keeps its value until the low byte is read or a write unlatches it.
    chk_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
        rd_state_reg == RD_HELD_HIGH_READ && !rd_cnt_lo && !wr_sc && !wr_cnt
        |=> rd_state_reg == RD_HELD_HIGH_READ && $stable(held_value_reg))
        else $error("latched counter readout changed before the other byte was read");

    // Request follows flag and enable one cycle later.
    chk_irq_request_gate: assert property (@(posedge core_clk) disable iff (rst)
        ##1 overflow_irq_req == ($past(overflow_flag_reg) && $past(overflow_irq_enable_reg)))
        else $error("overflow request does not match flag and enable");

    // Up counting never runs downwards.
    chk_up_mode_direction: assert property (@(posedge core_clk) disable iff (rst)
        !center_aligned_select_reg && count_tick && !background_debug_active && !overflow_event && !wr_cnt
        |=> counter_reg == $past(counter_reg) + 16'h0001)
        else $error("up mode counter did not increment");

    // No clock source means no count ticks two cycles on.
    chk_no_source_stops: assert property (@(posedge core_clk) disable iff (rst)
        clock_source_select_reg == tmrsc_pkg::TMRSC_CLK_NONE [*2] |-> !count_tick)
        else $error("count tick with no clock source");

    // Counter byte write zeroes the counter and unlatches the readout.
    chk_counter_write_zero: assert property (@(posedge core_clk) disable iff (rst)
        wr_cnt |=> counter_reg == 16'h0000 && rd_state_reg == RD_IDLE)
        else $error("counter write did not zero counter or unlatch readout");

    // Debug freezes both the counter and the readout latch state.
    chk_debug_freeze: assert property (@(posedge core_clk) disable iff (rst)
        background_debug_active && !wr_cnt && !wr_sc && !bus_req.wr ##1 background_debug_active
        |-> $stable(counter_reg) && $stable(rd_state_reg))
        else $error("counter or readout latch moved during debug");

    // A high-byte read latches and a following low read returns the latched low byte.
    chk_coherent_read: assert property (@(posedge core_clk) disable iff (rst)
        rd_cnt_hi && rd_state_reg == RD_IDLE && !background_debug_active ##1 rd_cnt_lo && !bus_req.wr
        |=> reg_rdata == $past(held_value_reg[7:0]) && held_value_reg == $past(counter_reg, 2))
        else $error("split counter read not coherent");

    // Status write returns the readout latch to idle.
    chk_status_write_unlatch: assert property (@(posedge core_clk) disable iff (rst)
        wr_sc |=> rd_state_reg == RD_IDLE)
        else $error("status write did not unlatch readout");
endmodule

// ===== timer_counter_status_control_tb.sv
// Self-checking testbench for the timer status/control register, counter readout and overflow interrupt.
`timescale 1ns/1ps
module timer_counter_status_control_tb;
    // Clock, reset and bus stimulus.
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    tmrsc_pkg::tmrsc_bus_req_s bus_req = '0;
    // Counter clock inputs and debug state, all driven by the bench.
    logic fixed_clk_in = 1'b0;
    logic ext_clk_in = 1'b0;
    logic background_debug_active = 1'b0;
    // Observed outputs.
    logic [7:0] reg_rdata;
    logic overflow_irq_req;
    logic irq;
    // Mismatch and comparison counters.
    int err_count = 0;
    int comparisons = 0;
    // Status/control shorthand: external source with prescale 1, and the register offset.
    localparam logic [7:0] SC_EXT = 8'h18;
    localparam logic [7:0] SC = tmrsc_pkg::OFS_STATUS_CONTROL;

    tmrsc_core uut (
        .core_clk(core_clk),
        .rst(rst),
        .bus_req(bus_req),
        .reg_rdata(reg_rdata),
        .fixed_clk_in(fixed_clk_in),
        .ext_clk_in(ext_clk_in),
        .background_debug_active(background_debug_active),
        .overflow_irq_req(overflow_irq_req),
        .irq(irq)
    );

    // The clock toggles every half period of 50 ns.
    always #50 core_clk = ~core_clk;

    // Compares one byte and reports a mismatch at once.
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe; the idle cycle after it keeps every drive in its own time step.
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // One-cycle read strobe; the data stand only in the cycle after the taking edge.
    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp, input string name);
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        check(name, exp, reg_rdata);
    endtask

    // Reads the counter high byte then low byte back to back, with no idle cycle between the strobes.
    task automatic chk16(input logic [15:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: tmrsc_pkg::OFS_COUNTER_HIGH, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.addr <= tmrsc_pkg::OFS_COUNTER_LOW;
        #1;
        check("counter high", exp[15:8], reg_rdata);
        @(posedge core_clk);
        bus_req <= '0;
        #1;
        check("counter low", exp[7:0], reg_rdata);
    endtask

    // Pulses the selected clock lines two cycles high, two low, so they stay at a quarter of core_clk.
    task automatic pulse(input logic [1:0] which, input int n);
        repeat (n) begin
            @(posedge core_clk);
            fixed_clk_in <= which[0];
            ext_clk_in <= which[1];
            repeat (2) @(posedge core_clk);
            fixed_clk_in <= 1'b0;
            ext_clk_in <= 1'b0;
            @(posedge core_clk);
        end
        // Let the edge detect and prescaler flops settle before anything is read.
        repeat (4) @(posedge core_clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 10000 cycles, so 30000 means a hang.
    initial begin
        #(30000 * 100);
        err_count++;
        wrap_up();
    end

    // Main test sequence.
    initial begin
        logic [1:0] src;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        reg_rd(SC, 8'h00, "status reset");
        chk16(16'h0000);
        reg_wr(8'h07, 8'hFF);
        reg_rd(8'h07, 8'h00, "unmapped read");
        reg_rd(SC, 8'h00, "status after unmapped write");
        // Source codes none, fixed and external: fixed-only pulses then external-only pulses tell the sources apart.
        for (int s = 0; s < 4; s++) begin
            src = 2'(s);
            if (s != 1) begin
                reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h00);
                reg_wr(SC, {3'b000, src, 3'b000});
                pulse(2'b01, 2);
                pulse(2'b10, 3);
                reg_rd(SC, {3'b000, src, 3'b000}, "status fields");
                chk16((s == 0) ? 16'd0 : ((s == 2) ? 16'd2 : 16'd3));
            end
        end
        // System clock source counts every cycle: 22 ticks land between the two status writes.
        reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h00);
        reg_wr(SC, 8'h08);
        repeat (20) @(posedge core_clk);
        reg_wr(SC, 8'h00);
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'h16, "system count");
        comparisons++;
        if ((reg_rdata >= 8'h10 && reg_rdata <= 8'h1A) !== 1'b1) begin
            err_count++;
            $display("ERROR system count expected 10..1A seen %h", reg_rdata);
        end
        // Every prescale code: 3 times the divisor in pulses gives exactly 3 counts whatever the phase.
        for (int ps = 0; ps < 8; ps++) begin
            reg_wr(tmrsc_pkg::OFS_COUNTER_HIGH, 8'hA5);
            reg_wr(SC, SC_EXT + 8'(ps));
            pulse(2'b10, 3 << ps);
            chk16(16'd3);
        end
        // Up-down counting to a top of 4, then down.
        reg_wr(tmrsc_pkg::OFS_MODULO_HIGH, 8'h00);
        reg_wr(tmrsc_pkg::OFS_MODULO_LOW, 8'h04);
        reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h00);
        reg_wr(SC, 8'h38);
        pulse(2'b10, 4);
        chk16(16'd4);
        pulse(2'b10, 1);
        chk16(16'd3);
        reg_rd(SC, 8'hB8, "flag at up-down top");
        reg_wr(SC, SC_EXT);
        reg_rd(SC, SC_EXT, "flag cleared by read then write");
        // Up counting: no flag at the top itself, flag on the tick after it.
        reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h00);
        pulse(2'b10, 4);
        reg_rd(SC, SC_EXT, "no flag at top");
        pulse(2'b10, 1);
        reg_rd(SC, 8'h98, "flag after wrap");
        check("request without enable", 8'h00, {7'h00, overflow_irq_req});
        reg_wr(SC, 8'hD8);
        repeat (2) @(posedge core_clk);
        check("request with enable", 8'h01, {7'h00, overflow_irq_req});
        reg_wr(SC, 8'h58);
        reg_rd(SC, 8'hD8, "clear without prior read");
        pulse(2'b10, 5);
        reg_wr(SC, 8'h58);
        reg_rd(SC, 8'hD8, "overflow between read and write");
        reg_wr(SC, 8'h58);
        reg_rd(SC, 8'h58, "flag cleared");
        repeat (2) @(posedge core_clk);
        check("request after clear", 8'h00, {7'h00, overflow_irq_req});
        // Sticky interrupt status, mask and the level output.
        reg_rd(tmrsc_pkg::OFS_IRQ_STATUS, 8'h01, "irq status");
        check("irq masked", 8'h00, {7'h00, irq});
        reg_wr(tmrsc_pkg::OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq unmasked", 8'h01, {7'h00, irq});
        reg_wr(tmrsc_pkg::OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq cleared", 8'h00, {7'h00, irq});
        reg_rd(tmrsc_pkg::OFS_IRQ_MASK, 8'h01, "irq mask");
        // Coherent readout across a high byte carry, free running.
        reg_wr(tmrsc_pkg::OFS_MODULO_LOW, 8'h00);
        reg_wr(SC, SC_EXT);
        reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h00);
        pulse(2'b10, 254);
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'hFE, "low latches");
        pulse(2'b10, 4);
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'hFE, "repeated low read");
        reg_rd(tmrsc_pkg::OFS_COUNTER_HIGH, 8'h00, "latched high");
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'h02, "fresh low");
        reg_rd(tmrsc_pkg::OFS_COUNTER_HIGH, 8'h01, "latched high pair");
        reg_rd(tmrsc_pkg::OFS_COUNTER_HIGH, 8'h01, "high latches");
        pulse(2'b10, 1);
        reg_wr(SC, SC_EXT);
        chk16(16'h0103);
        reg_rd(tmrsc_pkg::OFS_COUNTER_HIGH, 8'h01, "high latches again");
        reg_wr(tmrsc_pkg::OFS_COUNTER_LOW, 8'h55);
        chk16(16'h0000);
        // Debug freezes the counter and the half-finished readout.
        pulse(2'b10, 3);
        reg_rd(tmrsc_pkg::OFS_COUNTER_HIGH, 8'h00, "high before debug");
        @(posedge core_clk);
        background_debug_active <= 1'b1;
        pulse(2'b10, 2);
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'h03, "low in debug");
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'h03, "low in debug again");
        @(posedge core_clk);
        background_debug_active <= 1'b0;
        pulse(2'b10, 2);
        reg_rd(tmrsc_pkg::OFS_COUNTER_LOW, 8'h03, "low after debug");
        chk16(16'h0005);
        wrap_up();
    end
endmodule
